// >>> rso_status_out.sv
// Purpose: Drives the remote status outputs and screens remote inputs
// Assumes: Controller state inputs synchronous to core_clk
// Notes:   Outputs lag their cause by one cycle
`timescale 1ns/1ns
`default_nettype none

module rso_status_out #(
  parameter int CMD_N = 8,                     // Remote commands
  parameter int CYC_PER_TICK = rso_pkg::CYC_PER_TICK
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // Controller task state
  input  wire logic                         startup_done,
  input  wire logic                         task_running,
  input  wire logic                         task_paused,
  input  wire logic [rso_pkg::PROG_W-1:0]   program_index,
  // Fault events
  input  wire logic                         error_event,
  input  wire logic [rso_pkg::FAULT_W-1:0]  fault_code_in,
  input  wire logic                         critical_event,
  input  wire logic                         warning_in,
  // Safety and drive state
  input  wire logic                         estop_in,
  input  wire logic                         guard_in,
  input  wire logic                         motors_in,
  input  wire logic                         park_in,
  input  wire logic                         power_high_in,
  // Mode selection
  input  wire logic [rso_pkg::MODE_W-1:0]   op_mode,
  input  wire logic                         remote_selected,
  input  wire logic                         remote_io_enable,
  // Occupancy
  input  wire logic [rso_pkg::ZONE_N-1:0]   zone_in,
  input  wire logic [rso_pkg::ZONE_N-1:0]   plane_in,
  // Remote inputs
  input  wire logic [CMD_N-1:0]             remote_cmd_in,
  input  wire logic                         remote_reset_in,
  // Status outputs
  output logic                              ready_status,
  output logic                              running_status,
  output logic                              paused_status,
  output logic                              error_status,
  output logic                              emergency_stop_active,
  output logic                              guard_door_open,
  output logic                              critical_fault,
  output logic                              warning_status,
  output logic                              drive_power_on,
  output logic                              arm_at_park_position,
  output logic                              active_program_bit0,
  output logic                              active_program_bit1,
  output logic                              active_program_bit2,
  output logic                              remote_accept_status,
  output logic                              manual_jog_mode,
  output logic                              full_power_status,
  output logic [rso_pkg::FAULT_W-1:0]       fault_number,
  output logic [rso_pkg::ZONE_N-1:0]        zone_occupied,
  output logic [rso_pkg::ZONE_N-1:0]        plane_occupied,
  // Accepted remote commands
  output logic [CMD_N-1:0]                  cmd_accept,
  output logic                              reset_accept
);

  ////////////////////////////////////////////////////////////////////
  // True when more than one bit is set
  function automatic logic multi_hot(input logic [CMD_N:0] v);
    multi_hot = |(v & (v - {{CMD_N{1'b0}}, 1'b1}));
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_q;    // First stage, read only by the second
  logic rst_sync_q;    // Reset copy used everywhere

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Remote input qualification
  logic            tick;       // Width tick
  logic [CMD_N:0]  q_held;     // Reset is the top bit
  logic [CMD_N:0]  q_rise;     // Newly qualified inputs

  rso_tick_div #(
    .CYC (CYC_PER_TICK)
  ) u_div (
    .core_clk (core_clk),
    .rst_n    (rst_sync_q),
    .tick     (tick)
  );

  rso_pulse_qual #(
    .N (CMD_N + 1)
  ) u_qual (
    .core_clk (core_clk),
    .rst_n    (rst_sync_q),
    .tick     (tick),
    .lvl_in   ({remote_reset_in, remote_cmd_in}),
    .held     (q_held),
    .rise     (q_rise)
  );

  ////////////////////////////////////////////////////////////////////
  // Block state
  typedef struct packed {
    logic                        ready;
    logic                        running;
    logic                        paused;
    logic                        err;
    logic                        estop;
    logic                        guard;
    logic                        crit;
    logic                        warn;
    logic                        motors;
    logic                        park;
    logic [rso_pkg::PROG_W-1:0]  prog;
    logic                        accept;
    logic                        jog;
    logic                        power;
    logic [rso_pkg::FAULT_W-1:0] fault;
    logic [rso_pkg::ZONE_N-1:0]  zone;
    logic [rso_pkg::ZONE_N-1:0]  plane;
    logic [CMD_N-1:0]            cmd;
    logic                        rst_ok;
  } rso_state_type;

  rso_state_type s_q;
  rso_state_type s_d;

  logic overlap;       // Two remote inputs at once
  logic clear_ok;      // Accepted reset clears the error

  assign overlap  = multi_hot(q_held);
  // Reset is the one command still taken with an error
  assign clear_ok = q_rise[CMD_N] && s_q.accept;

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    // Plain status followers
    s_d.ready   = startup_done && !task_running;
    s_d.running = task_running;
    s_d.paused  = task_paused;
    s_d.estop   = estop_in;
    s_d.guard   = guard_in;
    s_d.warn    = warning_in;
    s_d.motors  = motors_in;
    s_d.park    = park_in;
    s_d.prog    = program_index;
    s_d.jog     = (op_mode == rso_pkg::MODE_TEACH);
    s_d.power   = power_high_in;
    s_d.zone    = zone_in;
    s_d.plane   = plane_in;
    // Remote acceptance in two modes only
    s_d.accept = ((op_mode == rso_pkg::MODE_AUTO) && remote_selected) ||
                 ((op_mode == rso_pkg::MODE_PROGRAM) && remote_io_enable);
    // Critical fault has no clear path but reset
    s_d.crit = s_q.crit || critical_event;
    // Error: clear first, so a new event wins
    if (clear_ok) begin
      s_d.err   = 1'b0;
      s_d.fault = rso_pkg::FAULT_NONE;
    end
    if (overlap) begin
      s_d.err   = 1'b1;
      s_d.fault = rso_pkg::FAULT_OVERLAP;
    end
    if (error_event) begin
      s_d.err   = 1'b1;
      s_d.fault = fault_code_in;
    end
    // Commands pass only with no error, remote enabled and no overlap
    if (s_q.err || !s_q.accept || overlap) begin
      s_d.cmd = '0;
    end else begin
      s_d.cmd = q_rise[CMD_N-1:0];
    end
    s_d.rst_ok = clear_ok;
  end

  ////////////////////////////////////////////////////////////////////
  // State register; all outputs low in reset
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign ready_status          = s_q.ready;
  assign running_status        = s_q.running;
  assign paused_status         = s_q.paused;
  assign error_status          = s_q.err;
  assign emergency_stop_active = s_q.estop;
  assign guard_door_open       = s_q.guard;
  assign critical_fault        = s_q.crit;
  assign warning_status        = s_q.warn;
  assign drive_power_on        = s_q.motors;
  assign arm_at_park_position  = s_q.park;
  assign active_program_bit0   = s_q.prog[0];
  assign active_program_bit1   = s_q.prog[1];
  assign active_program_bit2   = s_q.prog[2];
  assign remote_accept_status  = s_q.accept;
  assign manual_jog_mode       = s_q.jog;
  assign full_power_status     = s_q.power;
  assign fault_number          = s_q.fault;
  assign zone_occupied         = s_q.zone;
  assign plane_occupied        = s_q.plane;
  assign cmd_accept            = s_q.cmd;
  assign reset_accept          = s_q.rst_ok;

  ////////////////////////////////////////////////////////////////////
  // Checks
  ready_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 ready_status == $past(startup_done && !task_running))
    else $error("ready wrong");

  running_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    task_running |=> running_status) else $error("running missing");

  error_hold_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    (error_status && !clear_ok) |=> error_status) else $error("error dropped");

  estop_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    estop_in |=> emergency_stop_active) else $error("stop missing");

  crit_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    (critical_event || critical_fault) |=> critical_fault)
    else $error("critical cleared");

  prog_code_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 {active_program_bit2, active_program_bit1, active_program_bit0}
        == $past(program_index)) else $error("program code");

  accept_mode_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    remote_accept_status |-> $past(op_mode != rso_pkg::MODE_TEACH))
    else $error("accept in teach");

  fault_load_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    error_event |=> error_status && fault_number == $past(fault_code_in))
    else $error("fault number");

  overlap_err_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    overlap |=> error_status) else $error("overlap missed");

  reject_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    error_status |=> cmd_accept == '0) else $error("command in error");

  reset_clear_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    (clear_ok && !overlap && !error_event) |=> !error_status && reset_accept)
    else $error("reset ignored");

  zone_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 zone_occupied == $past(zone_in)) else $error("zone");

  paused_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 paused_status == $past(task_paused))
    else $error("paused wrong");

  guard_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 guard_door_open == $past(guard_in))
    else $error("guard wrong");

  warn_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 warning_status == $past(warning_in))
    else $error("warning wrong");

  motor_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 drive_power_on == $past(motors_in))
    else $error("motors wrong");

  park_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 arm_at_park_position == $past(park_in))
    else $error("park wrong");

  jog_mode_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 manual_jog_mode == $past(op_mode == rso_pkg::MODE_TEACH))
    else $error("jog wrong");

  power_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 full_power_status == $past(power_high_in))
    else $error("power wrong");

  plane_follow_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    ##1 plane_occupied == $past(plane_in))
    else $error("plane wrong");

  overlap_drop_a: assert property (@(posedge core_clk) disable iff (!rst_sync_q)
    overlap |=> cmd_accept == '0)
    else $error("overlap accepted");

endmodule

`default_nettype wire

// >>> rso_pkg.sv
// Purpose: Shared constants for the remote status outputs block
// Assumes: 100 MHz core clock
// Notes:   Mode codes are arbitrary encodings of the operating mode input
// How it works
// - Ready when started up, no task running
// - Running while a task executes
// - Paused while any paused task exists
// - Error sticky until remote reset input
// - Emergency stop indicator follows stop condition
// - Guard open indicator follows safeguard state
// - Critical fault cleared only by reboot
// - Warning indicator, tasks keep running
// - Drive power indicator follows motor state
// - Park position indicator follows arm position
// - Program index on three weighted lines
// - Remote accept: auto+remote or program+remote
// - Manual jog indicator in teach mode
// - Fault number on fourteen weighted lines
// - Fifteen zone occupancy indicators
// - Fifteen plane occupancy indicators
// - Full power indicator while power high
// - Error rejects commands until reset clears it

package rso_pkg;

  ////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PROG_W  = 3;   // Program index lines
  localparam int FAULT_W = 14;  // Fault number, weights 1..8192
  localparam int ZONE_N  = 15;  // Zone and plane indicators
  localparam int MODE_W  = 2;   // Operating mode code

  ////////////////////////////////////////////////////////////////////
  // Operating mode codes
  localparam logic [MODE_W-1:0] MODE_AUTO    = 2'h0;
  localparam logic [MODE_W-1:0] MODE_PROGRAM = 2'h1;
  localparam logic [MODE_W-1:0] MODE_TEACH   = 2'h2;

  ////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;        // Core clock period
  localparam int NS_PER_MS     = 1000000;   // Unit conversion
  localparam int TICK_MS       = 1;         // Qualifier tick
  localparam int PULSE_MIN_MS  = 25;        // Least remote pulse
  // Cycles per tick, rounded down to keep ticks no longer
  localparam int CYC_PER_TICK  = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
  // Tick phase is unknown, so one tick less guarantees detection
  localparam int PULSE_TICKS   = PULSE_MIN_MS / TICK_MS - 1;
  localparam int QCNT_W        = 5;         // Holds PULSE_TICKS

  ////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [FAULT_W-1:0] FAULT_NONE    = 14'h0000;
  localparam logic [FAULT_W-1:0] FAULT_OVERLAP = 14'h0001; // Arbitrary

endpackage

// >>> rso_tick_div.sv
// Purpose: One-cycle tick enable every CYC cycles
// Assumes: Synchronous active-low reset copy
// Notes:   Tick period sets qualifier resolution
`timescale 1ns/1ns
`default_nettype none

module rso_tick_div #(
  parameter int CYC = rso_pkg::CYC_PER_TICK
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Tick
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;   // Cycle counter
    logic        tick;  // Tick pulse
  } rso_div_type;

  rso_div_type s_q;
  rso_div_type s_d;

  ////////////////////////////////////////////////////////////////////
  // Count down to the tick
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'h0) begin
      s_d.cnt = 32'(CYC - 1);
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  // Ticks never come back to back unless CYC is one
  tick_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tick && CYC > 1) |=> !tick) else $error("tick too close");

endmodule

`default_nettype wire

// >>> rso_pulse_qual.sv
// Purpose: Qualifies remote input levels by least width
// Assumes: Inputs synchronous to core clock
// Notes:   Width measured in ticks from rso_tick_div
`timescale 1ns/1ns
`default_nettype none

module rso_pulse_qual #(
  parameter int N     = 9,
  parameter int TICKS = rso_pkg::PULSE_TICKS
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Inputs
  input  wire logic         tick,
  input  wire logic [N-1:0] lvl_in,
  // Qualified
  output logic      [N-1:0] held,
  output logic      [N-1:0] rise
);

  localparam int CW = rso_pkg::QCNT_W;
  localparam logic [CW-1:0] TOP = CW'(TICKS);

  typedef struct packed {
    logic [N-1:0][CW-1:0] cnt;   // Ticks seen while high
    logic [N-1:0]         held;  // Width reached
    logic [N-1:0]         rise;  // First cycle of held
  } rso_qual_type;

  rso_qual_type s_q;
  rso_qual_type s_d;

  ////////////////////////////////////////////////////////////////////
  // Per input width counter; a low level restarts it
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < N; i++) begin
      if (!lvl_in[i]) begin
        s_d.cnt[i] = '0;
      end else if (tick && s_q.cnt[i] != TOP) begin
        s_d.cnt[i] = s_q.cnt[i] + CW'(1);
      end
      s_d.held[i] = lvl_in[i] && (s_d.cnt[i] == TOP);
      s_d.rise[i] = s_d.held[i] && !s_q.held[i];
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign held = s_q.held;
  assign rise = s_q.rise;

  // A one-cycle pulse on input 0 never qualifies
  qual_input_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(held[0]) |-> $past(lvl_in[0]) && $past(lvl_in[0], 2))
    else $error("held without input");

endmodule

`default_nettype wire

// >>> rso_remote_host.sv
// Purpose: Model of the outside control device that drives remote inputs
// Assumes: Levels change just after the falling edge of core_clk
// Notes:   Overlap and short pulses happen only when a caller asks for them
`timescale 1ns/1ns
`default_nettype none

module rso_remote_host #(
  parameter int CMD_N = 8                  // Remote command lines
) (
  // Clock
  input  wire logic             core_clk,
  // Remote input levels
  output logic      [CMD_N-1:0] remote_cmd_in,
  output logic                  remote_reset_in
);

  ////////////////////////////////////////////////////////////////////
  // Inputs rest in the off state between operations
  initial begin
    remote_cmd_in   = '0;
    remote_reset_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // One operation: the lines in mask are held for cyc cycles
  task automatic pulse(input logic [CMD_N:0] mask, input int cyc);
    @(negedge core_clk);
    remote_cmd_in   = mask[CMD_N-1:0];
    remote_reset_in = mask[CMD_N];
    // Hold long enough to be seen unless the caller wants a short one
    repeat (cyc) @(negedge core_clk);
    remote_cmd_in   = '0;
    remote_reset_in = 1'b0;
    // Quiet gap so the next operation never overlaps this one
    repeat (8) @(negedge core_clk);
  endtask

endmodule
`default_nettype wire

// >>> test_remote_status_outputs.sv
// Purpose: Self-checking bench for the remote status outputs block
// Assumes: Tick shortened to 4 cycles, so 25 ticks span 100 cycles
// Notes:   A cycle model with sticky fault state is compared every edge
`timescale 1ns/1ns
`default_nettype none

module test_remote_status_outputs;

  ////////////////////////////////////////////////////////////////////
  // Bench constants and signals
  localparam int TICK = 4;                 // Short tick keeps the run brief
  localparam int FULL = 25 * TICK;         // Pulse that always qualifies
  logic        core_clk, rst_n;
  logic        startup_done, task_running, task_paused, error_event;
  logic        critical_event, warning_in, estop_in, guard_in, motors_in;
  logic        park_in, power_high_in, remote_selected, remote_io_enable;
  logic [2:0]  program_index;
  logic [1:0]  op_mode;
  logic [13:0] fault_code_in, fault_number, e_fault;
  logic [14:0] zone_in, plane_in, zone_occupied, plane_occupied;
  wire  logic [7:0] remote_cmd_in;
  wire  logic       remote_reset_in;
  logic        ready_status, running_status, paused_status, error_status;
  logic        emergency_stop_active, guard_door_open, critical_fault;
  logic        warning_status, drive_power_on, arm_at_park_position;
  logic        active_program_bit0, active_program_bit1, active_program_bit2;
  logic        remote_accept_status, manual_jog_mode, full_power_status;
  logic [7:0]  cmd_accept;
  logic        reset_accept;
  logic [68:0] all_o;                      // Every output, for reset checks
  logic        e_err, e_crit, e_acc;       // Model state
  logic        live, hbusy;                // Model running, remote op active
  logic [8:0]  cur_m;                      // Lines of the current operation
  int          tot, hit;                   // Accept pulses seen, on cur_m
  int          num_errors = 0;
  int          samples_checked = 0;

  assign all_o = {ready_status, running_status, paused_status, error_status,
    emergency_stop_active, guard_door_open, critical_fault, warning_status,
    drive_power_on, arm_at_park_position, active_program_bit0,
    active_program_bit1, active_program_bit2, remote_accept_status,
    manual_jog_mode, full_power_status, fault_number, zone_occupied,
    plane_occupied, cmd_accept, reset_accept};

  ////////////////////////////////////////////////////////////////////
  // Design and far-side model
  rso_status_out #(.CMD_N(8), .CYC_PER_TICK(TICK)) i_dut (
    .core_clk, .rst_n, .startup_done, .task_running, .task_paused,
    .program_index, .error_event, .fault_code_in, .critical_event,
    .warning_in, .estop_in, .guard_in, .motors_in, .park_in, .power_high_in,
    .op_mode, .remote_selected, .remote_io_enable, .zone_in, .plane_in,
    .remote_cmd_in, .remote_reset_in, .ready_status, .running_status,
    .paused_status, .error_status, .emergency_stop_active, .guard_door_open,
    .critical_fault, .warning_status, .drive_power_on, .arm_at_park_position,
    .active_program_bit0, .active_program_bit1, .active_program_bit2,
    .remote_accept_status, .manual_jog_mode, .full_power_status,
    .fault_number, .zone_occupied, .plane_occupied, .cmd_accept, .reset_accept);

  rso_remote_host #(.CMD_N(8)) i_host (
    .core_clk, .remote_cmd_in, .remote_reset_in);

  ////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [79:0] got, input logic [79:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Cycle model: outputs show the inputs of the edge just taken
  always @(posedge core_clk) begin
    #1;
    if (!rst_n) begin
      e_err = 1'b0;
      e_crit = 1'b0;
      e_fault = '0;
      chk(all_o, '0, "output set during reset");
    end else if (live) begin
      // Sticky faults load before the compare of this edge
      if (error_event) begin
        e_err = 1'b1;
        e_fault = fault_code_in;
      end
      if (critical_event) e_crit = 1'b1;
      e_acc = (op_mode == rso_pkg::MODE_AUTO && remote_selected) ||
              (op_mode == rso_pkg::MODE_PROGRAM && remote_io_enable);
      chk(ready_status, startup_done & !task_running, "ready");
      chk({running_status, paused_status}, {task_running, task_paused}, "task");
      chk({emergency_stop_active, guard_door_open}, {estop_in, guard_in}, "safety");
      chk(critical_fault, e_crit, "critical");
      chk(warning_status, warning_in, "warning");
      chk({drive_power_on, arm_at_park_position}, {motors_in, park_in}, "drive");
      chk({active_program_bit2, active_program_bit1, active_program_bit0},
          program_index, "program");
      chk(remote_accept_status, e_acc, "accept");
      chk(manual_jog_mode, op_mode == rso_pkg::MODE_TEACH, "jog");
      chk({zone_occupied, plane_occupied}, {zone_in, plane_in}, "zones");
      chk(full_power_status, power_high_in, "power");
      // Qualification moment is loose, so errors are judged after an op
      if (!hbusy) chk({error_status, fault_number}, {e_err, e_fault}, "error");
      if (!hbusy) chk({reset_accept, cmd_accept}, '0, "stray accept");
      tot += $countones({reset_accept, cmd_accept});
      hit += $countones({reset_accept, cmd_accept} & cur_m);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stimulus tasks, all changes at the falling edge
  task automatic idle();
    {startup_done, task_running, task_paused, error_event, critical_event} = '0;
    {warning_in, estop_in, guard_in, motors_in, park_in, power_high_in} = '0;
    {remote_selected, remote_io_enable, program_index, op_mode} = '0;
    {fault_code_in, zone_in, plane_in} = '0;
  endtask

  task automatic do_reset();
    @(negedge core_clk);
    rst_n = 1'b0;
    live = 1'b0;
    idle();
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    // Internal copy releases two edges later
    repeat (4) @(negedge core_clk);
    live = 1'b1;
  endtask

  task automatic rnd_phase(input int n);
    logic [31:0] r, s, t;
    repeat (n) begin
      @(negedge core_clk);
      r = $urandom;
      s = $urandom;
      t = $urandom;
      {startup_done, task_running, task_paused, warning_in, estop_in, guard_in,
       motors_in, park_in, power_high_in, remote_selected, remote_io_enable,
       program_index, op_mode} = r[15:0];
      zone_in = s[14:0];
      plane_in = s[29:15];
      fault_code_in = t[13:0];
      error_event = (t[18:14] == 5'h00);
      critical_event = (t[27:19] == 9'h000);
    end
    @(negedge core_clk);
    error_event = 1'b0;
    critical_event = 1'b0;
  endtask

  task automatic mode(input logic [1:0] m, input logic sel, input logic io);
    @(negedge core_clk);
    op_mode = m;
    remote_selected = sel;
    remote_io_enable = io;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic fault_evt(input logic [13:0] code, input logic crit);
    @(negedge core_clk);
    error_event = !crit;
    critical_event = crit;
    fault_code_in = code;
    @(negedge core_clk);
    error_event = 1'b0;
    critical_event = 1'b0;
  endtask

  // One remote operation, then the expected accept count and fault state
  task automatic remote(input logic [8:0] m, input int cyc);
    int n;
    int ex;
    n = $countones(m);
    ex = 0;
    hbusy = 1'b1;
    cur_m = m;
    tot = 0;
    hit = 0;
    i_host.pulse(m, cyc);
    if (cyc >= FULL && n > 1) begin
      e_err = 1'b1;
      e_fault = rso_pkg::FAULT_OVERLAP;
    end else if (cyc >= FULL && m[8] && e_acc) begin
      e_err = 1'b0;
      e_fault = rso_pkg::FAULT_NONE;
      ex = 1;
    end else if (cyc >= FULL && !e_err && e_acc) begin
      ex = 1;
    end
    if (n == 1) chk({tot, hit}, {ex, ex}, "accept count");
    else chk(tot, 0, "overlap accepted");
    hbusy = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    live = 1'b0;
    hbusy = 1'b0;
    {e_err, e_crit, e_acc, e_fault, cur_m, tot, hit} = '0;
    idle();
    void'($urandom(32'h3583a542));
    do_reset();
    rnd_phase(400);
    mode(rso_pkg::MODE_AUTO, 1'b1, 1'b0);
    remote(9'h100, FULL);
    for (int i = 0; i < 8; i++) remote(9'(1 << i), FULL);
    remote(9'h001, 15 * TICK);
    fault_evt(14'h2000, 1'b0);
    remote(9'h002, FULL);
    remote(9'h100, FULL);
    remote(9'h006, FULL);
    remote(9'h100, FULL);
    fault_evt(14'h1555, 1'b0);
    mode(rso_pkg::MODE_TEACH, 1'b1, 1'b1);
    remote(9'h100, FULL);
    mode(rso_pkg::MODE_PROGRAM, 1'b0, 1'b1);
    remote(9'h100, FULL);
    fault_evt(14'h0000, 1'b1);
    remote(9'h100, FULL);
    do_reset();
    rnd_phase(200);
    complete_run();
  end

endmodule
`default_nettype wire
